// >>> common/rst_clk_map.vh
// register map, field positions, reset values and timing counts
// Summary of operation
// - brown-out reset starts disabled, software enables
// - low supply raises interrupt or reset
// - reset only while brownout_reset_select set
// - brown-out reset acts like external reset
// - brown-out recorded in reset_cause_reg
// - lane written 1 holds peripheral reset
// - reset lanes match clock-gating lane order
// - lane reset drives every unit clock domain
// - core request resets whole system, then releases
// - after release fetch sp, pc, insn, run
// - watchdog interrupts first, resets second time-out
// - first time-out reloads 32-bit counter
// - second zero with interrupt pending resets
// - voltage adjust clamps 2.25 V to 2.75 V
// - fast internal oscillator is default clock
// - low-frequency oscillator selectable for deep sleep
// - clock mux offers six sources
// - extended config overrides base source, bypass and power-down fields, not crystal
// - crystal number passed unchanged as loop reference setting
// - cause bits sticky, power-on clears others
// - few cycles sync after external reset
`ifndef RST_CLK_MAP_VH
`define RST_CLK_MAP_VH
// register byte offsets
`define OFF_BOR_CTL     12'h000
`define OFF_RST_CAUSE   12'h004
`define OFF_PRST0       12'h008
`define OFF_PRST2       12'h010
`define OFF_REG_CTL     12'h014
`define OFF_RCC         12'h018
`define OFF_RCC_EXT     12'h01C
`define OFF_WD_LOAD     12'h020
`define OFF_WD_CTL      12'h024
`define OFF_WD_VALUE    12'h028
`define OFF_IRQ_STAT    12'h02C
`define OFF_PLL_CFG     12'h030
// brownout_control_reg fields
`define BOR_EN_BIT      0
`define BOR_RSEL_BIT    1
// reset_cause_reg fields
`define CAUSE_EXT       0
`define CAUSE_POR       1
`define CAUSE_BOR       2
`define CAUSE_WDT       3
`define CAUSE_SW        4
`define CAUSE_POR_VAL   5'h02
// irq status bits
`define IRQ_BOR_BIT     0
`define IRQ_WDT_BIT     1
// watchdog control bits
`define WD_EN_BIT       0
`define WD_RST_EN_BIT   1
// run_clock_config fields
`define RCC_SRC_LO      0
`define RCC_SRC_HI      2
`define RCC_CRYSTAL_SELECT_LO     6
`define RCC_CRYSTAL_SELECT_HI     10
`define RCC_BYPASS_BIT  11
`define RCC_PWRDN_BIT   13
`define RCC_USE_EXT_BIT 31
`define RCC_RST_VAL     32'h0000_2800
// clock source codes
`define SRC_FAST_OSC    3'h0
`define SRC_MAIN_OSC    3'h1
`define SRC_FAST_DIV4   3'h2
`define SRC_LOW_OSC     3'h3
`define SRC_RTC_OSC     3'h4
`define SRC_PLL         3'h5
// regulator adjust field
`define REGULATOR_VOLTAGE_ADJUST_HI         5
`define REGULATOR_VOLTAGE_ADJUST_MAX        6'h0A
// reset pulse for core and watchdog requests
`define RST_PULSE_NS    100
`endif

// >>> logic/reset_clock_ctrl.v
// reset merging, reset cause, watchdog and system clock selection
`timescale 1ns/100ps
`include "rst_clk_map.vh"
module reset_clock_ctrl #(
    parameter CLK_MHZ   = 200,
    parameter PRST_REGS = 3,
    parameter WD_W      = 32
) (
    input  wire                     clk,
    input  wire                     rst,
    input  wire                     psel,
    input  wire                     penable,
    input  wire                     pwrite,
    input  wire [11:0]              paddr,
    input  wire [31:0]              pwdata,
    output reg  [31:0]              prdata,
    output reg                      pready,
    output reg                      pslverr,
    input  wire                     ext_rst_n,
    input  wire                     supply_low,
    input  wire                     system_reset_request,
    input  wire                     fetch_done,
    output reg                      sys_rst,
    output reg  [PRST_REGS*32-1:0]  periph_rst,
    output reg                      bor_irq,
    output reg                      wdt_irq,
    output reg  [2:0]               clk_src_sel,
    output reg                      pll_pwrdn,
    output reg                      pll_bypass,
    output reg  [4:0]               pll_ref_setting,
    output reg                      pll_relock,
    output reg  [`REGULATOR_VOLTAGE_ADJUST_HI:0]        regulator_voltage_adjust,
    output reg                      fetch_req,
    output reg  [1:0]               fetch_kind,
    output reg                      core_run
);

    localparam integer RST_PULSE_CYC =
        (`RST_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam [7:0] PULSE_LEN = RST_PULSE_CYC[7:0];

    // boot fetch states
    localparam [1:0] ST_SP   = 2'h0;
    localparam [1:0] ST_PC   = 2'h1;
    localparam [1:0] ST_INSN = 2'h2;
    localparam [1:0] ST_RUN  = 2'h3;

    reg  [1:0]       bor_ctl_r;
    reg  [4:0]       cause_r;
    reg  [31:0]      prst_r [0:PRST_REGS-1];
    reg  [`REGULATOR_VOLTAGE_ADJUST_HI:0] regulator_voltage_adjust_r;
    reg  [31:0]      rcc_r;
    reg  [31:0]      rcc_ext_r;
    reg  [WD_W-1:0]  wd_load_r;
    reg  [1:0]       wd_ctl_r;
    reg  [WD_W-1:0]  wd_cnt_r;
    reg  [1:0]       irq_r;
    reg  [7:0]       pulse_cnt_r;
    reg              wd_fire_r;
    reg              sync1_r;
    reg              sync2_r;
    reg  [1:0]       boot_r;
    reg  [1:0]       boot_nxt;
    reg  [4:0]       crystal_select_prev_r;
    reg              pwrdn_prev_r;
    reg  [31:0]      rd_nxt;
    reg              err_nxt;

    wire acc      = psel & penable & pready;
    wire wr       = acc & pwrite;
    wire bor_act  = supply_low & bor_ctl_r[`BOR_EN_BIT];
    wire bor_rst  = bor_act & bor_ctl_r[`BOR_RSEL_BIT];
    wire bor_int  = bor_act & ~bor_ctl_r[`BOR_RSEL_BIT];
    wire wd_zero  = (wd_cnt_r == {WD_W{1'b0}});
    wire wd_en    = wd_ctl_r[`WD_EN_BIT];

    // brown-out joins the pin path, held while supply stays low
    wire rst_src  = rst | ~ext_rst_n | bor_rst |
                    (pulse_cnt_r != 8'h00);

    // extended config overrides the base source, bypass and power-down fields when selected; crystal select always comes from rcc_r
    wire use_ext  = rcc_ext_r[`RCC_USE_EXT_BIT];
    wire [31:0] rcc_eff = use_ext ? rcc_ext_r : rcc_r;
    wire [2:0] src_req  = rcc_eff[`RCC_SRC_HI:`RCC_SRC_LO];
    wire [4:0] crystal_select     = rcc_r[`RCC_CRYSTAL_SELECT_HI:`RCC_CRYSTAL_SELECT_LO];

    // async assert, two-flop synchronous release
    always @(posedge clk or posedge rst_src)
    begin
        if (rst_src)
        begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
        end
        else
        begin
            sync1_r <= 1'b0;
            sync2_r <= sync1_r;
        end
    end

    always @(posedge clk or posedge rst_src)
    begin
        if (rst_src)
            sys_rst <= 1'b1;
        else
            sys_rst <= sync2_r;
    end

    // pulse stretcher for core and watchdog requests
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pulse_cnt_r <= 8'h00;
        end
        else if (pulse_cnt_r != 8'h00)
            pulse_cnt_r <= pulse_cnt_r - 8'h01;
        else if (system_reset_request | wd_fire_r)
        begin
            pulse_cnt_r <= PULSE_LEN;
        end
    end

    // boot fetch order after release
    always @*
    begin
        boot_nxt = boot_r;
        case (boot_r)
            ST_SP:   if (fetch_done) boot_nxt = ST_PC;
            ST_PC:   if (fetch_done) boot_nxt = ST_INSN;
            ST_INSN: if (fetch_done) boot_nxt = ST_RUN;
            ST_RUN:  boot_nxt = ST_RUN;
            default: boot_nxt = ST_SP;
        endcase
    end

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            boot_r    <= ST_SP;
            fetch_req <= 1'b0;
            fetch_kind <= ST_SP;
            core_run  <= 1'b0;
        end
        else if (sys_rst)
        begin
            boot_r    <= ST_SP;
            fetch_req <= 1'b0;
            fetch_kind <= ST_SP;
            core_run  <= 1'b0;
        end
        else
        begin
            boot_r     <= boot_nxt;
            fetch_req  <= (boot_nxt != ST_RUN);
            fetch_kind <= boot_nxt;
            core_run   <= (boot_nxt == ST_RUN);
        end
    end

    // reset cause: power-on leaves only its own bit, others sticky
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            cause_r <= `CAUSE_POR_VAL;
        else
        begin
            cause_r[`CAUSE_EXT] <= ~ext_rst_n |
                (cause_r[`CAUSE_EXT] &
                 ~(wr && paddr == `OFF_RST_CAUSE && pwdata[`CAUSE_EXT]));
            cause_r[`CAUSE_POR] <= cause_r[`CAUSE_POR] &
                 ~(wr && paddr == `OFF_RST_CAUSE && pwdata[`CAUSE_POR]);
            cause_r[`CAUSE_BOR] <= bor_rst |
                (cause_r[`CAUSE_BOR] &
                 ~(wr && paddr == `OFF_RST_CAUSE && pwdata[`CAUSE_BOR]));
            cause_r[`CAUSE_WDT] <= wd_fire_r |
                (cause_r[`CAUSE_WDT] &
                 ~(wr && paddr == `OFF_RST_CAUSE && pwdata[`CAUSE_WDT]));
            cause_r[`CAUSE_SW] <= system_reset_request |
                (cause_r[`CAUSE_SW] &
                 ~(wr && paddr == `OFF_RST_CAUSE && pwdata[`CAUSE_SW]));
        end
    end

    // control registers survive system resets; only power-on clears them
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            bor_ctl_r <= 2'b00;
            regulator_voltage_adjust_r    <= {(`REGULATOR_VOLTAGE_ADJUST_HI+1){1'b0}};
            rcc_r     <= `RCC_RST_VAL;
            rcc_ext_r <= `RCC_RST_VAL;
            wd_load_r <= {WD_W{1'b1}};
        end
        else if (wr)
        begin
            case (paddr)
                `OFF_BOR_CTL: bor_ctl_r <= pwdata[1:0];
                `OFF_REG_CTL:
                    // out-of-range codes are clamped to the top step
                    if (pwdata[`REGULATOR_VOLTAGE_ADJUST_HI:0] > `REGULATOR_VOLTAGE_ADJUST_MAX)
                        regulator_voltage_adjust_r <= `REGULATOR_VOLTAGE_ADJUST_MAX;
                    else
                        regulator_voltage_adjust_r <= pwdata[`REGULATOR_VOLTAGE_ADJUST_HI:0];
                `OFF_RCC:     rcc_r     <= pwdata;
                `OFF_RCC_EXT: rcc_ext_r <= pwdata;
                `OFF_WD_LOAD: wd_load_r <= pwdata[WD_W-1:0];
                default:      bor_ctl_r <= bor_ctl_r;
            endcase
        end
    end

    // peripheral reset lanes, one generate entry per register
    genvar g;
    generate
        for (g = 0; g < PRST_REGS; g = g + 1)
        begin : g_prst
            always @(posedge clk or posedge rst)
            begin
                if (rst)
                    prst_r[g] <= 32'h0000_0000;
                else if (wr && paddr == `OFF_PRST0 + 12'h004 * g)
                    prst_r[g] <= pwdata;
            end
            // lane k of word g drives the unit whose clock gate is lane k;
            // the unit fans it out to all of its clock domains
            always @(posedge clk or posedge rst)
            begin
                if (rst)
                    periph_rst[g*32 +: 32] <= 32'h0000_0000;
                else
                    periph_rst[g*32 +: 32] <= prst_r[g];
            end
        end
    endgenerate

    // watchdog: first zero interrupts and reloads, second zero resets
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wd_ctl_r  <= 2'b00;
            wd_cnt_r  <= {WD_W{1'b1}};
            wd_fire_r <= 1'b0;
        end
        else if (sys_rst)
        begin
            wd_ctl_r  <= 2'b00;
            wd_cnt_r  <= wd_load_r;
            wd_fire_r <= 1'b0;
        end
        else
        begin
            wd_fire_r <= 1'b0;
            if (wr && paddr == `OFF_WD_CTL)
                wd_ctl_r <= pwdata[1:0];
            if (wr && paddr == `OFF_WD_LOAD)
                wd_cnt_r <= pwdata[WD_W-1:0];
            else if (wd_en && wd_zero)
            begin
                wd_cnt_r <= wd_load_r;
                wd_fire_r <= irq_r[`IRQ_WDT_BIT] &
                             wd_ctl_r[`WD_RST_EN_BIT];
            end
            else if (wd_en)
                wd_cnt_r <= wd_cnt_r - {{(WD_W-1){1'b0}}, 1'b1};
        end
    end

    // sticky interrupt flags; a new event beats a same-cycle clear
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            irq_r <= 2'b00;
        else if (sys_rst)
            irq_r <= 2'b00;
        else
        begin
            irq_r[`IRQ_BOR_BIT] <= bor_int |
                (irq_r[`IRQ_BOR_BIT] &
                 ~(wr && paddr == `OFF_IRQ_STAT && pwdata[`IRQ_BOR_BIT]));
            irq_r[`IRQ_WDT_BIT] <= (wd_en & wd_zero) |
                (irq_r[`IRQ_WDT_BIT] &
                 ~(wr && paddr == `OFF_IRQ_STAT && pwdata[`IRQ_WDT_BIT]));
        end
    end

    // clock selection; unknown codes keep the current source
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            clk_src_sel     <= `SRC_FAST_OSC;
            pll_pwrdn       <= 1'b1;
            pll_bypass      <= 1'b1;
            pll_ref_setting <= 5'h00;
            pll_relock      <= 1'b0;
            crystal_select_prev_r     <= 5'h00;
            pwrdn_prev_r    <= 1'b1;
        end
        else
        begin
            case (src_req)
                `SRC_FAST_OSC, `SRC_MAIN_OSC, `SRC_FAST_DIV4,
                `SRC_LOW_OSC, `SRC_RTC_OSC, `SRC_PLL:
                    clk_src_sel <= src_req;
                default:
                    clk_src_sel <= clk_src_sel;
            endcase
            pll_pwrdn    <= rcc_eff[`RCC_PWRDN_BIT];
            pll_bypass   <= rcc_eff[`RCC_BYPASS_BIT];
            pll_ref_setting <= crystal_select;
            crystal_select_prev_r  <= crystal_select;
            pwrdn_prev_r <= rcc_eff[`RCC_PWRDN_BIT];
            // same-value writes do not disturb the loop
            pll_relock <= (crystal_select != crystal_select_prev_r) |
                (pwrdn_prev_r & ~rcc_eff[`RCC_PWRDN_BIT]);
        end
    end

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            bor_irq <= 1'b0;
            wdt_irq <= 1'b0;
            regulator_voltage_adjust <= {(`REGULATOR_VOLTAGE_ADJUST_HI+1){1'b0}};
        end
        else
        begin
            bor_irq <= irq_r[`IRQ_BOR_BIT];
            wdt_irq <= irq_r[`IRQ_WDT_BIT];
            regulator_voltage_adjust <= regulator_voltage_adjust_r;
        end
    end

    // read decode, captured in the setup cycle
    always @*
    begin
        rd_nxt  = 32'h0000_0000;
        err_nxt = 1'b0;
        case (paddr)
            `OFF_BOR_CTL:   rd_nxt = {30'h0000_0000, bor_ctl_r};
            `OFF_RST_CAUSE: rd_nxt = {27'h000_0000, cause_r};
            `OFF_PRST0:     rd_nxt = prst_r[0];
            `OFF_PRST0 + 12'h004: rd_nxt = prst_r[1];
            `OFF_PRST2:     rd_nxt = prst_r[2];
            `OFF_REG_CTL:   rd_nxt = {26'h000_0000, regulator_voltage_adjust_r};
            `OFF_RCC:       rd_nxt = rcc_r;
            `OFF_RCC_EXT:   rd_nxt = rcc_ext_r;
            `OFF_WD_LOAD:   rd_nxt = wd_load_r;
            `OFF_WD_CTL:    rd_nxt = {30'h0000_0000, wd_ctl_r};
            `OFF_WD_VALUE:  rd_nxt = wd_cnt_r;
            `OFF_IRQ_STAT:  rd_nxt = {30'h0000_0000, irq_r};
            `OFF_PLL_CFG:   rd_nxt = {27'h000_0000, pll_ref_setting};
            default:        err_nxt = 1'b1;
        endcase
    end

    // one wait-free access cycle: pready rises in the first access cycle
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & err_nxt;
            if (psel & ~penable & ~pwrite)
                prdata <= rd_nxt;
        end
    end

endmodule // reset_clock_ctrl

// >>> bench/core_fetch_model.sv
// boot fetch responder standing in for the core
`timescale 1ns/100ps
module core_fetch_model (
    input  wire clk,
    input  wire rst,
    input  wire slow,
    input  wire fetch_req,
    output reg  fetch_done
);
    reg [2:0] wait_r;
    // one done pulse per fetch after 1 or 4 stall cycles
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            fetch_done <= 1'b0;
            wait_r     <= 3'h0;
        end
        else if (!fetch_req || fetch_done)
        begin
            fetch_done <= 1'b0;
            wait_r     <= 3'h0;
        end
        else if (wait_r < (slow ? 3'h4 : 3'h1))
            wait_r <= wait_r + 3'h1;
        else
            fetch_done <= 1'b1;
    end
endmodule // core_fetch_model

// >>> bench/reset_clock_ctrl_chk.sv
// assertion checker for the reset and clock control block
`timescale 1ns/100ps
`include "rst_clk_map.vh"
module reset_clock_ctrl_chk #(
    parameter PRST_REGS = 3
) (
    input wire                    clk,
    input wire                    rst,
    input wire                    psel,
    input wire                    penable,
    input wire                    pwrite,
    input wire [11:0]             paddr,
    input wire [31:0]             pwdata,
    input wire                    pready,
    input wire                    ext_rst_n,
    input wire                    supply_low,
    input wire                    system_reset_request,
    input wire                    fetch_done,
    input wire                    sys_rst,
    input wire [PRST_REGS*32-1:0] periph_rst,
    input wire                    bor_irq,
    input wire                    wdt_irq,
    input wire                    fetch_req,
    input wire [1:0]              fetch_kind,
    input wire                    core_run
);
    // shadows rebuilt from bus writes, since the registers are hidden
    reg        bor_en_r;
    reg        bor_sel_r;
    reg [31:0] lane0_r;
    wire       wr = psel & penable & pready & pwrite;
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            bor_en_r  <= 1'b0;
            bor_sel_r <= 1'b0;
            lane0_r   <= 32'h0000_0000;
        end
        else if (wr && paddr == `OFF_BOR_CTL)
        begin
            bor_en_r  <= pwdata[`BOR_EN_BIT];
            bor_sel_r <= pwdata[`BOR_RSEL_BIT];
        end
        else if (wr && paddr == `OFF_PRST0)
            lane0_r <= pwdata;
    end
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (rst);
    bor_reset_a:
        assert property (bor_en_r && bor_sel_r && supply_low |=> sys_rst)
        else $error("brown-out left reset low");
    bor_irq_a:
        assert property (bor_en_r && !bor_sel_r && supply_low |->
            ##[1:3] bor_irq) else $error("brown-out interrupt missing");
    ext_reset_a:
        assert property (!ext_rst_n |=> sys_rst)
        else $error("pin reset not passed on");
    sw_reset_a:
        assert property (system_reset_request |=> sys_rst)
        else $error("core request not passed on");
    sync_release_a:
        assert property ($fell(sys_rst) |-> $past(ext_rst_n, 3))
        else $error("reset released too early");
    boot_first_a:
        assert property ($fell(sys_rst) |->
            ##[0:2] (fetch_req && fetch_kind == 2'h0))
        else $error("boot does not start with stack fetch");
    boot_step_a:
        assert property (fetch_req && fetch_done && fetch_kind == 2'h0
            |-> ##[1:2] fetch_kind == 2'h1) else $error("pc fetch missed");
    boot_run_a:
        assert property (fetch_req && fetch_done && fetch_kind == 2'h2
            |-> ##[1:2] core_run) else $error("run not entered");
    lane_hold_a:
        assert property (wr && paddr == `OFF_PRST0 |->
            ##2 periph_rst[31:0] == lane0_r) else $error("lane reset wrong");
    cover property (wdt_irq ##[1:200] sys_rst);
    cover property (bor_irq && !sys_rst);
    cover property ($rose(core_run));
endmodule // reset_clock_ctrl_chk
bind reset_clock_ctrl reset_clock_ctrl_chk #(.PRST_REGS(PRST_REGS))
    reset_clock_ctrl_chk_inst (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .ext_rst_n, .supply_low, .system_reset_request, .fetch_done, .sys_rst,
    .periph_rst, .bor_irq, .wdt_irq, .fetch_req, .fetch_kind, .core_run
);

// >>> bench/test_reset_sources_and_clock_select.sv
// self-checking bench for the reset and clock control block
`timescale 1ns/100ps
`include "rst_clk_map.vh"
module test_reset_sources_and_clock_select;
    reg         clk, rst, psel, penable, pwrite, ext_rst_n;
    reg         supply_low, system_reset_request, slow, err_seen;
    reg  [11:0] paddr;
    reg  [31:0] pwdata, rd;
    wire [31:0] prdata;
    wire        pready, pslverr, sys_rst, bor_irq, wdt_irq, fetch_req;
    wire        fetch_done, core_run, pll_pwrdn, pll_bypass, pll_relock;
    wire [95:0] periph_rst;
    wire [2:0]  clk_src_sel;
    wire [4:0]  pll_ref_setting;
    wire [5:0]  regulator_voltage_adjust;
    wire [1:0]  fetch_kind;
    integer     miscompares, n_compared, i;
    reset_clock_ctrl reset_clock_ctrl_inst (
        .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .ext_rst_n, .supply_low, .system_reset_request,
        .fetch_done, .sys_rst, .periph_rst, .bor_irq, .wdt_irq,
        .clk_src_sel, .pll_pwrdn, .pll_bypass, .pll_ref_setting,
        .pll_relock, .regulator_voltage_adjust, .fetch_req, .fetch_kind,
        .core_run
    );
    core_fetch_model core_fetch_model_inst (
        .clk, .rst, .slow, .fetch_req, .fetch_done
    );
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task report_and_stop(input integer hung);
    begin
        miscompares = miscompares + hung;
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask
    task check(input [31:0] seen, input [31:0] exp);
    begin
        n_compared = n_compared + 1;
        if (seen !== exp)
        begin
            miscompares = miscompares + 1;
            $display("unexpected at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    end
    endtask
    // holds the request until pready is sampled high at a rising edge
    task apb(input [11:0] a, input w, input [31:0] d);
        integer n;
    begin
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 50 && pready !== 1'b1; n = n + 1)
            @(posedge clk);
        if (n == 50)
            report_and_stop(1);
        rd       = prdata;
        err_seen = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    end
    endtask
    task wait_sig(input integer s, input integer lim);
        integer n;
    begin
        for (n = 0; n <= lim && (s == 0 ? sys_rst : s == 1 ? core_run :
             s == 2 ? wdt_irq : bor_irq) !== 1'b1; n = n + 1)
            @(posedge clk);
        if (n > lim)
            report_and_stop(1);
    end
    endtask
    task boot(input [31:0] cause);
    begin
        // let the reset reach the boot logic, or a stale run level passes
        @(posedge clk);
        wait_sig(1, 300);
        apb(`OFF_RST_CAUSE, 1'b0, 32'h0000_0000);
        check(rd, cause);
        apb(`OFF_RST_CAUSE, 1'b1, 32'h0000_001F);
    end
    endtask
    task src(input [11:0] a, input [31:0] d, input [2:0] e);
    begin
        apb(a, 1'b1, d);
        repeat (2) @(posedge clk);
        check(clk_src_sel, e);
    end
    endtask
    initial
    begin
        miscompares = 0;
        n_compared = 0;
        rst = 1'b1;
        ext_rst_n = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = 0;
        {supply_low, system_reset_request, slow} = 3'b000;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        boot(32'h0000_0002);
        check(clk_src_sel, `SRC_FAST_OSC);
        check({pll_pwrdn, pll_bypass}, 2'b11);
        apb(`OFF_RCC, 1'b0, 32'h0000_0000);
        check(rd, `RCC_RST_VAL);
        apb(12'h100, 1'b0, 32'h0000_0000);
        check({err_seen, rd[30:0]}, 32'h8000_0000);
        // give main_osc time to settle before selecting it
        repeat (8) @(posedge clk);
        for (i = 0; i < 6; i = i + 1)
            src(`OFF_RCC, 32'h0000_2800 + i, i);
        src(`OFF_RCC_EXT, 32'h8000_2803, `SRC_LOW_OSC);
        src(`OFF_RCC_EXT, 32'h0000_2800, `SRC_PLL);
        // an unknown source code keeps the current source
        src(`OFF_RCC, 32'h0000_2806, `SRC_PLL);
        // crystal number inside the loop's reference range
        apb(`OFF_RCC, 1'b1, 32'h0000_2AC0);
        apb(`OFF_PLL_CFG, 1'b0, 32'h0000_0000);
        check(rd, 32'h0000_000B);
        check(pll_ref_setting, 5'h0B);
        // powering the loop up relocks it, a same-value write does not
        apb(`OFF_RCC, 1'b1, 32'h0000_0AC0);
        repeat (2) @(posedge clk);
        check({pll_relock, pll_pwrdn, pll_bypass}, 3'b101);
        @(posedge clk);
        check(pll_relock, 1'b0);
        apb(`OFF_RCC, 1'b1, 32'h0000_0AC0);
        repeat (2) @(posedge clk);
        check(pll_relock, 1'b0);
        apb(`OFF_REG_CTL, 1'b1, 32'h0000_003F);
        apb(`OFF_REG_CTL, 1'b0, 32'h0000_0000);
        check(rd, `REGULATOR_VOLTAGE_ADJUST_MAX);
        check(regulator_voltage_adjust, `REGULATOR_VOLTAGE_ADJUST_MAX);
        apb(`OFF_PRST0, 1'b1, 32'h0000_0F0F);
        apb(`OFF_PRST0 + 12'h004, 1'b1, 32'h0000_00F0);
        apb(`OFF_PRST2, 1'b1, 32'h8000_0001);
        repeat (20) @(posedge clk);
        check(periph_rst[95:64], 32'h8000_0001);
        check(periph_rst[63:32], 32'h0000_00F0);
        check(periph_rst[31:0], 32'h0000_0F0F);
        apb(`OFF_PRST0 + 12'h004, 1'b0, 32'h0000_0000);
        check(rd, 32'h0000_00F0);
        apb(`OFF_PRST0, 1'b1, 32'h0000_0000);
        apb(`OFF_PRST0 + 12'h004, 1'b1, 32'h0000_0000);
        apb(`OFF_PRST2, 1'b1, 32'h0000_0000);
        supply_low <= 1'b1;
        repeat (10) @(posedge clk);
        check({bor_irq, sys_rst}, 2'b00);
        apb(`OFF_BOR_CTL, 1'b1, 32'h0000_0001);
        wait_sig(3, 20);
        check(sys_rst, 1'b0);
        apb(`OFF_BOR_CTL, 1'b1, 32'h0000_0003);
        wait_sig(0, 10);
        repeat (30) @(posedge clk);
        check(sys_rst, 1'b1);
        supply_low <= 1'b0;
        boot(32'h0000_0004);
        apb(`OFF_BOR_CTL, 1'b1, 32'h0000_0000);
        ext_rst_n <= 1'b0;
        wait_sig(0, 5);
        ext_rst_n <= 1'b1;
        @(posedge clk);
        wait_sig(1, 300);
        slow <= 1'b1;
        system_reset_request <= 1'b1;
        wait_sig(0, 5);
        system_reset_request <= 1'b0;
        // pin cause kept across the later reset
        boot(32'h0000_0011);
        apb(`OFF_WD_LOAD, 1'b1, 32'h0000_0040);
        apb(`OFF_WD_CTL, 1'b1, 32'h0000_0003);
        wait_sig(2, 100);
        apb(`OFF_WD_VALUE, 1'b0, 32'h0000_0000);
        check(rd > 32'h0000_0030 && rd < 32'h0000_0040, 1);
        wait_sig(0, 100);
        boot(32'h0000_0008);
        report_and_stop(0);
    end
endmodule // test_reset_sources_and_clock_select
